// file: shared/mzt_pkg.sv
/*
 * constants for the mask test and guard timer execution block.
 * assumes an APB master with 32-bit data and a 10 MHz pclk.
 */
// Functional notes
// - mask test sets zero flag when dst AND mask is zero, else clears.
// - mask test copies bit 7 of the AND result into the sign flag.
// - mask test clears overflow; decimal-adjust and half-carry flags stay unchanged.
// - operand byte with high nibble 1110b selects a working register of the group.
// - mask test only derives flags; neither operand is written back.
// - guard timer is a retriggerable one-shot; terminal count raises a full reset.
// - first kick opcode enables the timer; later kicks restart its count.
// - sleep-keep opcode makes the timer keep counting during halt.
// - without sleep-keep, the timer stops counting on entry to halt.
// - sleep-keep opcode neither clears nor reloads the count.
// - sleep-keep before the timer was ever enabled has no effect.
package mzt_pkg;
    // register byte offsets
    localparam logic [11:0] MZT_OFF_CTRL = 12'h000;
    localparam logic [11:0] MZT_OFF_DST = 12'h004;
    localparam logic [11:0] MZT_OFF_SRC = 12'h008;
    localparam logic [11:0] MZT_OFF_FLAGS = 12'h00c;
    localparam logic [11:0] MZT_OFF_STAT = 12'h010;
    localparam logic [11:0] MZT_OFF_CNT = 12'h014;
    localparam logic [11:0] MZT_OFF_RP = 12'h018;
    localparam logic [11:0] MZT_OFF_WR = 12'h01c;
    // opcodes
    localparam logic [7:0] MZT_OP_TM_RR = 8'h72;
    localparam logic [7:0] MZT_OP_TM_RIR = 8'h73;
    localparam logic [7:0] MZT_OP_TM_R_R = 8'h74;
    localparam logic [7:0] MZT_OP_TM_R_IR = 8'h75;
    localparam logic [7:0] MZT_OP_TM_R_IM = 8'h76;
    localparam logic [7:0] MZT_OP_TM_IR_IM = 8'h77;
    localparam logic [7:0] MZT_OP_KICK = 8'h5f;
    localparam logic [7:0] MZT_OP_SLEEP_KEEP = 8'h4f;
    localparam logic [3:0] MZT_WREG_NIBBLE = 4'he;
    // flag bit positions: c z s v d h
    localparam int MZT_FLAG_Z = 6;
    localparam int MZT_FLAG_S = 5;
    localparam int MZT_FLAG_V = 4;
    localparam int MZT_FLAG_D = 3;
    localparam int MZT_FLAG_H = 2;
    localparam logic [7:0] MZT_FLAGS_RST = 8'h00;
    // control bits
    localparam int MZT_CTRL_GO = 0;
    localparam int MZT_CTRL_HALT = 1;
    // cycles per opcode, and the guard timer terminal count
    localparam int MZT_CYC_SHORT = 6;
    localparam int MZT_CYC_LONG = 10;
    localparam int MZT_GUARD_TC_DEF = 65535;
endpackage : mzt_pkg

// file: rtl/mzt_regram.sv
/*
 * 256 x 8 register file for the execution block.
 * one write port, two registered read ports.
 */
`timescale 1ns/1ps
module mzt_regram #(
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    output logic [7:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [7:0] rdata_b
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end
endmodule // mzt_regram

// file: rtl/mzt_guard.sv
/*
 * retriggerable one-shot guard timer.
 * kick and sleep_keep are one-cycle pulses from the executing core.
 */
`timescale 1ns/1ps
module mzt_guard #(
    parameter int TC = mzt_pkg::MZT_GUARD_TC_DEF,
    parameter int CW = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic kick,
    input wire logic sleep_keep,
    input wire logic halted,
    output logic enabled_r,
    output logic keep_r,
    output logic [CW-1:0] count_r,
    output logic expire_r
);
    initial begin
        if (TC < 1 || CW < 2 || TC >= (64'd1 << CW)) begin
            $error("mzt_guard: bad terminal count or width");
        end
    end

    wire run = enabled_r && !(halted && !keep_r);
    wire at_tc = (count_r == CW'(TC));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enabled_r <= 1'b0;
            keep_r <= 1'b0;
            count_r <= '0;
            expire_r <= 1'b0;
        end else begin
            if (kick) begin
                enabled_r <= 1'b1;
                count_r <= '0;
            end else if (run && !at_tc) begin
                count_r <= count_r + CW'(1);
            end
            if (sleep_keep && enabled_r) begin
                keep_r <= 1'b1;
            end
            expire_r <= run && at_tc && !kick;
        end
    end

    a_kick_clears: assert property (@(posedge pclk) disable iff (!presetn)
        kick |=> (count_r == '0 && enabled_r)) else $error("kick did not restart");
    a_keep_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_keep && !enabled_r) |=> !keep_r) else $error("keep set while off");
    a_keep_no_reload: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_keep && !kick && run && !at_tc) |=> count_r == $past(count_r) + CW'(1))
        else $error("keep disturbed count");
    a_halt_stops: assert property (@(posedge pclk) disable iff (!presetn)
        (halted && !keep_r && !kick && !sleep_keep) |=> $stable(count_r))
        else $error("count ran in halt");
endmodule // mzt_guard

// file: rtl/mzt_exec.sv
/*
 * execution of the mask test and guard timer opcodes, APB programmed.
 * software loads opcode bytes, then pulses go; state and flags read back.
 */
`timescale 1ns/1ps
module mzt_exec #(
    parameter int GUARD_TC = mzt_pkg::MZT_GUARD_TC_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic guard_reset_r
);
    typedef enum logic [2:0] {
        MZT_IDLE, MZT_FETCH1, MZT_FETCH2, MZT_WAIT, MZT_DONE
    } mzt_state_t;

    mzt_state_t state_r, state_nxt;
    logic [7:0] op_r, dst_r, src_r, flags_r, rp_r;
    logic halt_r, busy_r, kick_p, keep_p, ill_r;
    logic [3:0] cyc_r;
    logic [7:0] a_val, b_val;
    logic [31:0] gcount;
    logic gen, gkeep, gexp;

    // effective register address, working-register escape
    function automatic logic [7:0] mzt_eff(input logic [7:0] b, input logic [7:0] rp);
        mzt_eff = (b[7:4] == mzt_pkg::MZT_WREG_NIBBLE) ? {rp[7:4], b[3:0]} : b;
    endfunction

    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire hit_ctrl = paddr == mzt_pkg::MZT_OFF_CTRL;
    wire hit_dst = paddr == mzt_pkg::MZT_OFF_DST;
    wire hit_src = paddr == mzt_pkg::MZT_OFF_SRC;
    wire hit_flg = paddr == mzt_pkg::MZT_OFF_FLAGS;
    wire hit_stat = paddr == mzt_pkg::MZT_OFF_STAT;
    wire hit_cnt = paddr == mzt_pkg::MZT_OFF_CNT;
    wire hit_rp = paddr == mzt_pkg::MZT_OFF_RP;
    wire hit_wr = paddr == mzt_pkg::MZT_OFF_WR;
    wire mapped = hit_ctrl | hit_dst | hit_src | hit_flg | hit_stat | hit_cnt | hit_rp | hit_wr;
    wire go = wr && hit_ctrl && pwdata[mzt_pkg::MZT_CTRL_GO] && !busy_r;

    // operand kinds by opcode
    wire op_short = op_r == mzt_pkg::MZT_OP_TM_RR || op_r == mzt_pkg::MZT_OP_TM_RIR;
    wire op_tm = op_r[7:3] == 5'b01110 && op_r[2:0] >= 3'd2;
    wire src_imm = op_r == mzt_pkg::MZT_OP_TM_R_IM || op_r == mzt_pkg::MZT_OP_TM_IR_IM;
    wire src_ind = op_r == mzt_pkg::MZT_OP_TM_RIR || op_r == mzt_pkg::MZT_OP_TM_R_IR;
    wire dst_ind = op_r == mzt_pkg::MZT_OP_TM_IR_IM;
    // short forms carry two 4-bit working register numbers
    wire [7:0] d_byte = op_short ? {mzt_pkg::MZT_WREG_NIBBLE, dst_r[7:4]} : dst_r;
    wire [7:0] s_byte = op_short ? {mzt_pkg::MZT_WREG_NIBBLE, dst_r[3:0]} : src_r;
    wire [7:0] d_addr1 = mzt_eff(d_byte, rp_r);
    wire [7:0] s_addr1 = mzt_eff(s_byte, rp_r);

    // second fetch follows pointers for indirect modes
    logic [7:0] ra_addr, rb_addr;
    wire [7:0] dst_val = a_val;
    wire [7:0] src_val = src_imm ? src_r : b_val;
    wire [7:0] and_res = dst_val & src_val;
    wire [3:0] cyc_need = 4'(op_short ? mzt_pkg::MZT_CYC_SHORT : mzt_pkg::MZT_CYC_LONG);
    wire [3:0] cyc_wd = 4'(mzt_pkg::MZT_CYC_SHORT);

    logic ptr_d_r, ptr_s_r;
    // pointer targets held through the wait cycles, the ram read is registered
    logic [7:0] pa_r, pb_r;
    wire in_ptr = state_r == MZT_FETCH2 || state_r == MZT_WAIT;
    always_comb begin
        ra_addr = d_addr1;
        rb_addr = s_addr1;
        if (in_ptr) begin
            if (ptr_d_r) begin
                ra_addr = (state_r == MZT_FETCH2) ? a_val : pa_r;
            end
            if (ptr_s_r) begin
                rb_addr = (state_r == MZT_FETCH2) ? b_val : pb_r;
            end
        end
    end

    mzt_regram #(.AW(8)) u_ram (
        .clk(pclk),
        .we(wr && hit_wr && !busy_r),
        .waddr(pwdata[15:8]),
        .wdata(pwdata[7:0]),
        .raddr_a(ra_addr),
        .rdata_a(a_val),
        .raddr_b(rb_addr),
        .rdata_b(b_val)
    );

    mzt_guard #(.TC(GUARD_TC), .CW(32)) u_guard (
        .pclk(pclk),
        .presetn(presetn),
        .kick(kick_p),
        .sleep_keep(keep_p),
        .halted(halt_r),
        .enabled_r(gen),
        .keep_r(gkeep),
        .count_r(gcount),
        .expire_r(gexp)
    );

    wire is_kick = op_r == mzt_pkg::MZT_OP_KICK;
    wire is_keep = op_r == mzt_pkg::MZT_OP_SLEEP_KEEP;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MZT_IDLE: state_nxt = go ? MZT_FETCH1 : MZT_IDLE;
            MZT_FETCH1: state_nxt = (op_tm && (src_ind || dst_ind)) ? MZT_FETCH2 : MZT_WAIT;
            MZT_FETCH2: state_nxt = MZT_WAIT;
            MZT_WAIT: begin
                if (!op_tm && !is_kick && !is_keep) begin
                    state_nxt = MZT_DONE;
                end else if (cyc_r >= (op_tm ? cyc_need : cyc_wd) - 4'd1) begin
                    state_nxt = MZT_DONE;
                end
            end
            MZT_DONE: state_nxt = MZT_IDLE;
            default: state_nxt = MZT_IDLE;
        endcase
    end

    // flags computed at completion
    wire fin = state_r == MZT_WAIT && state_nxt == MZT_DONE;
    logic [7:0] flags_nxt;
    always_comb begin
        flags_nxt = flags_r;
        if (op_tm) begin
            flags_nxt[mzt_pkg::MZT_FLAG_Z] = and_res == 8'h00;
            flags_nxt[mzt_pkg::MZT_FLAG_S] = and_res[7];
            flags_nxt[mzt_pkg::MZT_FLAG_V] = 1'b0;
        end else if (is_kick || is_keep) begin
            // zero, sign, overflow left as they were; d and h kept
            flags_nxt = flags_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= MZT_IDLE;
            op_r <= 8'h00;
            dst_r <= 8'h00;
            src_r <= 8'h00;
            rp_r <= 8'h00;
            flags_r <= mzt_pkg::MZT_FLAGS_RST;
            halt_r <= 1'b0;
            busy_r <= 1'b0;
            ill_r <= 1'b0;
            cyc_r <= 4'h0;
            ptr_d_r <= 1'b0;
            ptr_s_r <= 1'b0;
            pa_r <= 8'h00;
            pb_r <= 8'h00;
            kick_p <= 1'b0;
            keep_p <= 1'b0;
            guard_reset_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            busy_r <= state_nxt != MZT_IDLE;
            guard_reset_r <= gexp;
            kick_p <= fin && is_kick;
            keep_p <= fin && is_keep;
            cyc_r <= (state_r == MZT_IDLE) ? 4'h1 : cyc_r + 4'd1;
            if (state_r == MZT_FETCH1) begin
                ptr_d_r <= dst_ind;
                ptr_s_r <= src_ind;
            end
            if (state_r == MZT_FETCH2) begin
                pa_r <= a_val;
                pb_r <= b_val;
            end
            if (fin) begin
                flags_r <= flags_nxt;
                ill_r <= !op_tm && !is_kick && !is_keep;
            end
            if (wr && !busy_r) begin
                if (hit_ctrl) begin
                    halt_r <= pwdata[mzt_pkg::MZT_CTRL_HALT];
                end
                if (hit_dst) begin
                    op_r <= pwdata[15:8];
                    dst_r <= pwdata[7:0];
                end
                if (hit_src) begin
                    src_r <= pwdata[7:0];
                end
                if (hit_rp) begin
                    rp_r <= pwdata[7:0];
                end
                if (hit_flg) begin
                    flags_r <= pwdata[7:0];
                end
            end
        end
    end

    // apb answer: one wait-free access phase, registered read data
    wire [31:0] rd_mux =
        hit_ctrl ? {30'h0, halt_r, busy_r} :
        hit_dst ? {16'h0, op_r, dst_r} :
        hit_src ? {24'h0, src_r} :
        hit_flg ? {24'h0, flags_r} :
        hit_stat ? {28'h0, ill_r, gexp, gkeep, gen} :
        hit_cnt ? gcount :
        hit_rp ? {24'h0, rp_r} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
        end
    end

    a_tm_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (fin && op_tm) |=> flags_r[mzt_pkg::MZT_FLAG_Z] == ($past(and_res) == 8'h00))
        else $error("zero flag wrong");
    a_tm_sign_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (fin && op_tm) |=> flags_r[mzt_pkg::MZT_FLAG_S] == $past(and_res[7]))
        else $error("sign flag wrong");
    a_tm_v_dh: assert property (@(posedge pclk) disable iff (!presetn)
        (fin && op_tm) |=> !flags_r[mzt_pkg::MZT_FLAG_V] && $stable(flags_r[3:2]))
        else $error("v, d or h wrong");
    a_wd_keeps_dh: assert property (@(posedge pclk) disable iff (!presetn)
        (fin && (is_kick || is_keep)) |=> $stable(flags_r[3:2]))
        else $error("d or h changed");
    a_wreg_escape: assert property (@(posedge pclk) disable iff (!presetn)
        (dst_r[7:4] == 4'he && !op_short) |-> d_addr1 == {rp_r[7:4], dst_r[3:0]})
        else $error("escape decode wrong");
    a_tm_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        busy_r |-> !(wr && hit_wr)) else $error("ram written in op");
    a_guard_reset_out: assert property (@(posedge pclk) disable iff (!presetn)
        gexp |=> guard_reset_r) else $error("reset not raised");
    a_kick_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (fin && is_kick) |=> kick_p ##1 !kick_p) else $error("kick pulse wrong");
endmodule // mzt_exec

// file: tb/tb_mask_test_and_watchdog_ops.sv
/* self-checking bench for mzt_exec: mask test flags and guard timer.
   assumes an apb slave that answers one cycle after setup. */
`timescale 1ns/1ps
module tb_mask_test_and_watchdog_ops;
    localparam int TC = 60;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} mzt_exp_t;
    logic pclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic guard_reset_r;
    logic [2:0] hold = 3'h0;
    wire presetn = rst_n & (hold == 3'h0);
    int n_errors = 0;
    int checks_done = 0;
    int n_exp = 0;
    mzt_exp_t q[$];
    mzt_exp_t cur;
    logic [31:0] rv;
    logic [31:0] c1;
    logic [7:0] op;
    logic [7:0] d;
    logic [7:0] m;
    logic [7:0] fl;

    initial begin
        forever #50 pclk = ~pclk;
    end

    mzt_exec #(.GUARD_TC(TC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .guard_reset_r(guard_reset_r));

    // timer expiry held as a full reset for four cycles
    always @(posedge pclk) begin
        if (guard_reset_r === 1'b1) begin
            hold <= 3'h4;
            n_exp <= n_exp + 1;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic hang();
        n_errors++;
        complete_run();
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && q.size() > 0) begin
            cur = q.pop_front();
            check({31'h0, pslverr}, {31'h0, cur.e});
            if (cur.m != 32'h0) check(prdata & cur.m, cur.d & cur.m);
        end
    end

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        input logic [31:0] ed, input logic [31:0] em, input logic ee);
        int k;
        q.push_back('{ed, em, ee});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) hang();
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        xfer(1'b1, a, wd, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [31:0] em);
        xfer(1'b0, a, 32'h0, ed, em, 1'b0);
    endtask

    task automatic ram(input logic [7:0] a, input logic [7:0] v);
        wr(mzt_pkg::MZT_OFF_WR, {16'h0, a, v});
    endtask

    task automatic go();
        int k;
        k = 0;
        wr(mzt_pkg::MZT_OFF_CTRL, 32'h1);
        do begin
            rd(mzt_pkg::MZT_OFF_CTRL, 32'h0, 32'h0);
            k++;
        end while (rv[0] !== 1'b0 && k < 40);
        if (k >= 40) hang();
    endtask

    task automatic run(input logic [7:0] o, input logic [7:0] b1, input logic [7:0] b2);
        wr(mzt_pkg::MZT_OFF_DST, {16'h0, o, b1});
        wr(mzt_pkg::MZT_OFF_SRC, {24'h0, b2});
        go();
    endtask

    task automatic wait_exp(input int want);
        int k;
        k = 0;
        while (n_exp < want && k < 150) begin
            @(posedge pclk);
            k++;
        end
        repeat (8) @(posedge pclk);
    endtask

    // z from result, s from bit 7, v cleared, d and h kept
    function automatic logic [31:0] flg(input logic [7:0] f, input logic [7:0] r);
        flg = {24'h0, f[7], r == 8'h0, r[7], 1'b0, f[3:0]};
    endfunction

    initial begin
        void'($urandom(13));
        repeat (4) @(posedge pclk);
        rst_n <= 1'b1;
        @(posedge pclk);
        rd(mzt_pkg::MZT_OFF_FLAGS, {24'h0, mzt_pkg::MZT_FLAGS_RST}, 32'hff);
        rd(mzt_pkg::MZT_OFF_STAT, 32'h0, 32'hf);
        xfer(1'b0, 12'h020, 32'h0, 32'h0, 32'hffffffff, 1'b1);
        xfer(1'b1, 12'h024, 32'h5, 32'h0, 32'h0, 1'b1);
        wr(mzt_pkg::MZT_OFF_RP, 32'h70);
        for (int i = 0; i < 18; i++) begin
            op = mzt_pkg::MZT_OP_TM_RR + 8'(i % 6);
            d = 8'($urandom);
            m = (i < 6) ? 8'h80 : (i < 12) ? 8'h01 << ($urandom % 8) : 8'($urandom);
            fl = 8'($urandom);
            wr(mzt_pkg::MZT_OFF_FLAGS, {24'h0, fl});
            case (i % 6)
                0: begin
                    ram(8'h73, d);
                    ram(8'h77, m);
                    run(op, 8'h37, 8'h00);
                end
                1: begin
                    ram(8'h7e, d);
                    ram(8'h75, 8'hcb);
                    ram(8'hcb, m);
                    run(op, 8'he5, 8'h00);
                end
                2: begin
                    ram(8'hd4, d);
                    ram(8'h70, m);
                    ram(8'he0, ~m);
                    run(op, 8'hd4, 8'he0);
                end
                3: begin
                    ram(8'hdf, d);
                    ram(8'h07, 8'h1f);
                    ram(8'h1f, m);
                    run(op, 8'hdf, 8'h07);
                end
                4: begin
                    ram(8'h7d, d);
                    ram(8'hed, ~d);
                    run(op, 8'hed, m);
                end
                default: begin
                    ram(8'h5d, 8'ha0);
                    ram(8'ha0, d);
                    run(op, 8'h5d, m);
                end
            endcase
            rd(mzt_pkg::MZT_OFF_FLAGS, flg(fl, d & m), 32'h7c);
            if (i % 6 == 4) begin
                run(op, 8'hed, ~m);
                rd(mzt_pkg::MZT_OFF_FLAGS, flg(fl, d & ~m), 32'h7c);
            end
        end
        wr(mzt_pkg::MZT_OFF_FLAGS, 32'h0c);
        run(mzt_pkg::MZT_OP_SLEEP_KEEP, 8'h00, 8'h00);
        rd(mzt_pkg::MZT_OFF_STAT, 32'h0, 32'h3);
        run(mzt_pkg::MZT_OP_KICK, 8'h00, 8'h00);
        rd(mzt_pkg::MZT_OFF_STAT, 32'h1, 32'h3);
        rd(mzt_pkg::MZT_OFF_FLAGS, 32'h0c, 32'h0c);
        for (int i = 0; i < 5; i++) go();
        check(n_exp, 0);
        repeat (25) @(posedge pclk);
        rd(mzt_pkg::MZT_OFF_CNT, 32'h0, 32'h0);
        c1 = rv;
        go();
        rd(mzt_pkg::MZT_OFF_CNT, 32'h0, 32'h0);
        check(rv < c1, 1);
        wr(mzt_pkg::MZT_OFF_DST, {16'h0, mzt_pkg::MZT_OP_SLEEP_KEEP, 8'h00});
        repeat (15) @(posedge pclk);
        rd(mzt_pkg::MZT_OFF_CNT, 32'h0, 32'h0);
        c1 = rv;
        go();
        rd(mzt_pkg::MZT_OFF_CNT, 32'h0, 32'h0);
        check(rv > c1, 1);
        rd(mzt_pkg::MZT_OFF_STAT, 32'h3, 32'h3);
        rd(mzt_pkg::MZT_OFF_FLAGS, 32'h0c, 32'h0c);
        wr(mzt_pkg::MZT_OFF_CTRL, 32'h2);
        wait_exp(1);
        check(n_exp, 1);
        rd(mzt_pkg::MZT_OFF_STAT, 32'h0, 32'h3);
        run(mzt_pkg::MZT_OP_KICK, 8'h00, 8'h00);
        wr(mzt_pkg::MZT_OFF_CTRL, 32'h2);
        rd(mzt_pkg::MZT_OFF_CNT, 32'h0, 32'h0);
        c1 = rv;
        repeat (80) @(posedge pclk);
        rd(mzt_pkg::MZT_OFF_CNT, c1, 32'hffffffff);
        check(n_exp, 1);
        wr(mzt_pkg::MZT_OFF_CTRL, 32'h0);
        wait_exp(2);
        check(n_exp, 2);
        complete_run();
    end
endmodule // tb_mask_test_and_watchdog_ops
